/* hw/adcc_top.sv */
`include "adcc_regs.svh"

module adcc_top
  import adcc_pkg::*;
#(
  parameter int MEM_AW = 4
) (
  input wire logic clk_i, // 50 MHz system clock
  input wire logic reset_n_i, // Async reset, active low
  input wire logic [15:0] avs_address_i, // Avalon byte address
  input wire logic avs_read_i, // Avalon read
  input wire logic avs_write_i, // Avalon write
  input wire logic [31:0] avs_writedata_i, // Avalon write data
  input wire logic [3:0] avs_byteenable_i, // Avalon byte enables
  output logic [31:0] avs_readdata_o, // Avalon read data
  output logic avs_waitrequest_o, // Avalon wait request
  input wire logic mod_bit_i, // Modulator bit stream pin
  output logic sample_clk_o, // Gated sampling clock
  output logic decim_clk_o, // Gated decimator clock
  output logic decim_reset_n_o, // Decimator reset, active low
  output logic converter_enable_o, // Analog core enable
  output logic [3:0] channel_select_o // Analog mux select
);

  // ----------------------------------------
  // Decode helpers
  // ----------------------------------------
  function automatic logic [16:0] rate_step(input logic [1:0] code);
    case (code)
      2'h0: rate_step = 17'(`ADCC_STEP(`ADCC_SAMPLE_1M_HZ));
      2'h1: rate_step = 17'(`ADCC_STEP(`ADCC_SAMPLE_2M_HZ));
      2'h2: rate_step = 17'(`ADCC_STEP(`ADCC_SAMPLE_4M_HZ));
      default: rate_step = 17'h0_0000;
    endcase
  endfunction

  function automatic logic [8:0] osr_len(input logic [1:0] code);
    case (code)
      2'h1: osr_len = `ADCC_OSR_64;
      2'h2: osr_len = `ADCC_OSR_128;
      2'h3: osr_len = `ADCC_OSR_256;
      default: osr_len = 9'h000;
    endcase
  endfunction

  // ----------------------------------------
  // Bus slave
  // ----------------------------------------
  logic bus_req, bus_done, lane0;
  logic [13:0] idx;
  logic [7:0] rd_byte;
  logic sample_gate, decim_gate, buffer_mode;
  logic [1:0] rate_sel, osr_sel;
  logic [3:0] depth;
  adcc_phase_t phase;
  adcc_sample_t head, hold;
  logic [3:0] cnt, cap, fill;
  logic [MEM_AW-1:0] rd_ptr, wr_ptr, next_rd_ptr;
  logic full, pop, accept, store, adv_rd, overwritten;

  assign idx = avs_address_i[15:2];
  assign bus_req = avs_read_i || avs_write_i;
  assign bus_done = bus_req && !avs_waitrequest_o;
  assign lane0 = avs_write_i && bus_done && avs_byteenable_i[0];

  // One-cycle answer: waitrequest drops the cycle after a request is seen
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      avs_waitrequest_o <= 1'b1;
    end else begin
      avs_waitrequest_o <= !(bus_req && avs_waitrequest_o);
    end
  end

  always_comb begin
    rd_byte = 8'h00;
    case (idx)
      `ADCC_IDX_CONFIG_A: rd_byte = {converter_enable_o, 3'h0, channel_select_o};
      `ADCC_IDX_BUFFER_CONFIG: rd_byte = {depth, osr_sel, buffer_mode, 1'b0};
      `ADCC_IDX_STATUS: rd_byte = {1'b0, fill, 3'h0};
      `ADCC_IDX_RESULT: begin
        if (phase == ADCC_PH_HIGH) begin
          rd_byte = hold.hi;
        end else if (cnt != 4'h0) begin
          rd_byte = head.lo;
        end
      end
      `ADCC_IDX_CLOCK_GATES: rd_byte = {4'h0, sample_gate, decim_gate, 2'h0};
      `ADCC_IDX_DECIM_RESET: rd_byte = {1'b0, decim_reset_n_o, 6'h00};
      `ADCC_IDX_SAMPLE_RATE: rd_byte = {6'h00, rate_sel};
      default: rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      avs_readdata_o <= 32'h0000_0000;
    end else if (avs_read_i && avs_waitrequest_o) begin
      avs_readdata_o <= {24'h00_0000, rd_byte};
    end
  end

  // ----------------------------------------
  // Control registers
  // ----------------------------------------
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      converter_enable_o <= 1'b0;
      channel_select_o <= `ADCC_RST_CHANNEL;
    end else if (lane0 && idx == `ADCC_IDX_CONFIG_A) begin
      converter_enable_o <= avs_writedata_i[`ADCC_BIT_ENABLE];
      channel_select_o <= avs_writedata_i[3:0];
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      depth <= `ADCC_RST_DEPTH;
      osr_sel <= `ADCC_RST_OSR;
      buffer_mode <= 1'b0;
    end else if (lane0 && idx == `ADCC_IDX_BUFFER_CONFIG) begin
      depth <= avs_writedata_i[`ADCC_POS_DEPTH +: 4];
      osr_sel <= avs_writedata_i[`ADCC_POS_OSR +: 2];
      buffer_mode <= avs_writedata_i[`ADCC_BIT_BUFFER_MODE];
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sample_gate <= 1'b0;
      decim_gate <= 1'b0;
      decim_reset_n_o <= `ADCC_RST_DECIM_RESET_N;
      rate_sel <= `ADCC_RST_RATE;
    end else if (lane0) begin
      if (idx == `ADCC_IDX_CLOCK_GATES) begin
        sample_gate <= avs_writedata_i[`ADCC_BIT_SAMPLE_GATE];
        decim_gate <= avs_writedata_i[`ADCC_BIT_DECIM_GATE];
      end
      if (idx == `ADCC_IDX_DECIM_RESET) begin
        decim_reset_n_o <= avs_writedata_i[`ADCC_BIT_DECIM_RESET_N];
      end
      if (idx == `ADCC_IDX_SAMPLE_RATE) begin
        rate_sel <= avs_writedata_i[1:0];
      end
    end
  end

  // ----------------------------------------
  // Clock generation
  // ----------------------------------------
  // 50 MHz does not divide evenly; NCOs trade a little jitter for a near-exact average rate (steps are truncated)
  logic [15:0] s_acc, d_acc;
  logic [16:0] s_sum, d_sum;
  logic sample_tick;

  assign s_sum = {1'b0, s_acc} + rate_step(rate_sel);
  assign d_sum = {1'b0, d_acc} + 17'(`ADCC_STEP(`ADCC_DECIM_HZ));
  assign sample_tick = sample_gate && s_sum[16] && !sample_clk_o;

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s_acc <= 16'h0000;
      sample_clk_o <= 1'b0;
    end else if (!sample_gate) begin
      s_acc <= 16'h0000;
      sample_clk_o <= 1'b0;
    end else begin
      s_acc <= s_sum[15:0];
      sample_clk_o <= sample_clk_o ^ s_sum[16];
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      d_acc <= 16'h0000;
      decim_clk_o <= 1'b0;
    end else if (!decim_gate) begin
      d_acc <= 16'h0000;
      decim_clk_o <= 1'b0;
    end else begin
      d_acc <= d_sum[15:0];
      decim_clk_o <= decim_clk_o ^ d_sum[16];
    end
  end

  // ----------------------------------------
  // Decimator
  // ----------------------------------------
  logic mod_s1, mod_s2, active, dec_valid, skid_ready;
  logic [8:0] ones, ticks, osr_n;
  logic [15:0] dec_value;

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      mod_s1 <= 1'b0;
      mod_s2 <= 1'b0;
    end else begin
      mod_s1 <= mod_bit_i;
      mod_s2 <= mod_s1;
    end
  end

  assign osr_n = osr_len(osr_sel);
  assign active = converter_enable_o && sample_gate && decim_gate && decim_reset_n_o
    && (osr_n != 9'h000);

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ones <= 9'h000;
      ticks <= 9'h000;
      dec_valid <= 1'b0;
      dec_value <= 16'h0000;
    end else if (!active) begin
      ones <= 9'h000;
      ticks <= 9'h000;
      dec_valid <= 1'b0;
    end else begin
      if (dec_valid && skid_ready) begin
        dec_valid <= 1'b0;
      end
      // Ticks arriving while a result waits are skipped, not queued
      if (sample_tick && !(dec_valid && !skid_ready)) begin
        if (ticks == osr_n - 9'h001) begin
          ones <= 9'h000;
          ticks <= 9'h000;
          dec_valid <= 1'b1;
          // Full-scale count saturates instead of wrapping to zero
          if (ones + 9'(mod_s2) == osr_n) begin
            dec_value <= 16'hFFFF;
          end else begin
            dec_value <= 16'((32'(ones) + 32'(mod_s2)) * (32'h0001_0000 / 32'(osr_n)));
          end
        end else begin
          ones <= ones + 9'(mod_s2);
          ticks <= ticks + 9'h001;
        end
      end
    end
  end

  // ----------------------------------------
  // Two-entry skid buffer
  // ----------------------------------------
  logic [15:0] skid0, skid1;
  logic [1:0] skid_cnt;
  logic skid_valid, drain_ready, s_in, s_out;

  assign skid_ready = skid_cnt != 2'h2;
  assign skid_valid = skid_cnt != 2'h0;
  assign drain_ready = !pop;
  assign s_in = dec_valid && skid_ready;
  assign s_out = skid_valid && drain_ready;

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      skid_cnt <= 2'h0;
      skid0 <= 16'h0000;
      skid1 <= 16'h0000;
    end else if (!active) begin
      skid_cnt <= 2'h0;
    end else begin
      skid_cnt <= skid_cnt + 2'(s_in) - 2'(s_out);
      if (s_out) begin
        skid0 <= skid1;
      end
      if (s_in && (skid_cnt == 2'h0 || (skid_cnt == 2'h1 && s_out))) begin
        skid0 <= dec_value;
      end else if (s_in) begin
        skid1 <= dec_value;
      end
    end
  end

  // ----------------------------------------
  // Result buffer
  // ----------------------------------------
  logic rd_result;

  assign cap = (depth == 4'h0) ? 4'h0 : depth - 4'h1;
  assign full = cnt >= cap;
  assign rd_result = avs_read_i && bus_done && idx == `ADCC_IDX_RESULT;
  assign pop = rd_result && phase == ADCC_PH_HIGH && !overwritten && cnt != 4'h0;
  assign accept = s_out && active;
  assign store = accept && cap != 4'h0 && (!full || !buffer_mode);
  assign adv_rd = pop || (store && full);
  assign next_rd_ptr = adv_rd ? rd_ptr + MEM_AW'(1) : rd_ptr;
  assign fill = (cnt == 4'h0) ? 4'h0 : cnt + 4'h1;

  adcc_mem #(
    .WIDTH(16),
    .AW(MEM_AW)
  ) u_mem (
    .clk_i(clk_i),
    .we_i(store),
    .waddr_i(wr_ptr),
    .wdata_i(skid0),
    .raddr_i(next_rd_ptr),
    .rdata_o(head)
  );

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rd_ptr <= '0;
      wr_ptr <= '0;
      cnt <= 4'h0;
    end else begin
      rd_ptr <= next_rd_ptr;
      if (store) begin
        wr_ptr <= wr_ptr + MEM_AW'(1);
      end
      if (store && !full) begin
        cnt <= cnt + 4'h1;
      end else if (pop) begin
        cnt <= cnt - 4'h1;
      end
    end
  end

  // High byte is latched with the low byte so the pair stays consistent
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      phase <= ADCC_PH_LOW;
      hold <= '0;
      overwritten <= 1'b0;
    end else begin
      if (store && full && phase == ADCC_PH_HIGH) begin
        overwritten <= 1'b1;
      end
      if (rd_result) begin
        case (phase)
          ADCC_PH_LOW: begin
            if (cnt != 4'h0) begin
              hold <= head;
              phase <= ADCC_PH_HIGH;
              overwritten <= 1'b0;
            end
          end
          ADCC_PH_HIGH: phase <= ADCC_PH_LOW;
          default: phase <= ADCC_PH_LOW;
        endcase
      end
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  wait_pulse_a: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("waitrequest low for more than one cycle");
  read_answer_a: assert property (avs_read_i && avs_waitrequest_o |=> !avs_waitrequest_o ##0 avs_readdata_o[31:8] == 24'h00_0000)
    else $error("read not answered next cycle");
  sample_off_a: assert property (!sample_gate |=> !sample_clk_o)
    else $error("sampling clock runs while gated");
  decim_off_a: assert property (!decim_gate [*2] |-> !decim_clk_o)
    else $error("decimator clock runs while gated");
  no_push_a: assert property (store |-> converter_enable_o && sample_gate && decim_gate && decim_reset_n_o)
    else $error("sample stored while converter inactive");
  fifo_drop_a: assert property (buffer_mode && full && accept |=> cnt == $past(cnt) && rd_ptr == $past(rd_ptr))
    else $error("full FIFO accepted a sample");
  history_a: assert property (!buffer_mode && full && accept && cap != 4'h0 |=> rd_ptr == $past(rd_ptr) + MEM_AW'(1))
    else $error("history buffer did not drop oldest");
  pair_pop_a: assert property (rd_result && phase == ADCC_PH_LOW && cnt != 4'h0 |=> phase == ADCC_PH_HIGH ##0 $stable(cnt) || store)
    else $error("low byte read changed fill");
  fill_field_a: assert property (cnt != 4'h0 |-> fill == cnt + 4'h1)
    else $error("fill count field wrong");

endmodule // adcc_top

/* hw/adcc_regs.svh */
`ifndef ADCC_REGS_SVH
`define ADCC_REGS_SVH

// ----------------------------------------
// Register indexes (byte address = 4 * index)
// ----------------------------------------
`define ADCC_IDX_CONFIG_A 14'h22D4
`define ADCC_IDX_BUFFER_CONFIG 14'h22D5
`define ADCC_IDX_STATUS 14'h22D6
`define ADCC_IDX_RESULT 14'h22D7
`define ADCC_IDX_CLOCK_GATES 14'h2781
`define ADCC_IDX_DECIM_RESET 14'h2784
`define ADCC_IDX_SAMPLE_RATE 14'h2786

// ----------------------------------------
// Field positions
// ----------------------------------------
`define ADCC_BIT_ENABLE 7
`define ADCC_BIT_SAMPLE_GATE 3
`define ADCC_BIT_DECIM_GATE 2
`define ADCC_BIT_DECIM_RESET_N 6
`define ADCC_BIT_BUFFER_MODE 1
`define ADCC_POS_DEPTH 4
`define ADCC_POS_OSR 2
`define ADCC_POS_FILL 3

// ----------------------------------------
// Reset values
// ----------------------------------------
`define ADCC_RST_RATE 2'h2
`define ADCC_RST_DEPTH 4'hC
`define ADCC_RST_OSR 2'h3
`define ADCC_RST_DECIM_RESET_N 1'b1
`define ADCC_RST_CHANNEL 4'h0

// ----------------------------------------
// Timing: clock rates and NCO steps
// ----------------------------------------
`define ADCC_CLK_HZ 64'd50000000
`define ADCC_DECIM_HZ 64'd16000000
`define ADCC_SAMPLE_1M_HZ 64'd1000000
`define ADCC_SAMPLE_2M_HZ 64'd2000000
`define ADCC_SAMPLE_4M_HZ 64'd4000000
`define ADCC_NCO_W 16
`define ADCC_STEP(hz) (((64'd2 * (hz)) << `ADCC_NCO_W) / `ADCC_CLK_HZ)

// ----------------------------------------
// Oversampling ratios
// ----------------------------------------
`define ADCC_OSR_64 9'd64
`define ADCC_OSR_128 9'd128
`define ADCC_OSR_256 9'd256

`endif

/* hw/adcc_pkg.sv */
package adcc_pkg;

  // Result word split into the two bytes of the result port
  typedef struct packed {
    logic [7:0] hi;
    logic [7:0] lo;
  } adcc_sample_t;

  // Which byte of the result port the next read returns
  typedef enum logic [1:0] {
    ADCC_PH_LOW = 2'b01,
    ADCC_PH_HIGH = 2'b10
  } adcc_phase_t;

endpackage : adcc_pkg

/* hw/adcc_mem.sv */
module adcc_mem #(
  parameter int WIDTH = 16,
  parameter int AW = 4
) (
  input wire logic clk_i, // System clock
  input wire logic we_i, // Write strobe
  input wire logic [AW-1:0] waddr_i, // Write address
  input wire logic [WIDTH-1:0] wdata_i, // Write data
  input wire logic [AW-1:0] raddr_i, // Read address
  output logic [WIDTH-1:0] rdata_o // Registered read data
);

  logic [WIDTH-1:0] mem [0:(1<<AW)-1];

  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
  end

  // Bypass so a word written into an empty buffer is visible at once
  always_ff @(posedge clk_i) begin
    if (we_i && (waddr_i == raddr_i)) begin
      rdata_o <= wdata_i;
    end else begin
      rdata_o <= mem[raddr_i];
    end
  end

endmodule // adcc_mem

/* tb/adcc_mod_model.sv */
// ----------------------------------------
// Modulator bit stream model
// ----------------------------------------
module adcc_mod_model (
  input wire logic clk_i, // System clock
  input wire logic sample_clk_i, // Gated sampling clock
  input wire logic converter_enable_i, // Analog core enable
  input wire logic [3:0] channel_select_i, // Analog mux select
  output logic mod_bit_o // Modulator bit stream
);
  timeunit 1ns;
  timeprecision 1ps;

  logic prev_s = 1'b0;
  logic toggle = 1'b0;

  initial mod_bit_o = 1'b0;

  always @(posedge clk_i) begin
    prev_s <= sample_clk_i;
    if (!converter_enable_i) begin
      // Core off: line carries junk, never a stale level
      mod_bit_o <= ~mod_bit_o;
    end else if (sample_clk_i && !prev_s) begin
      toggle <= ~toggle;
      case (channel_select_i)
        4'h7: mod_bit_o <= 1'b1;
        4'h8: mod_bit_o <= 1'b0;
        // Inputs at midscale: exactly half ones in any even-length window
        default: mod_bit_o <= toggle;
      endcase
    end
  end
endmodule // adcc_mod_model

/* tb/test_adc_digital_control.sv */
`include "adcc_regs.svh"

module test_adc_digital_control;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [13:0] CA = `ADCC_IDX_CONFIG_A;
  localparam logic [13:0] BC = `ADCC_IDX_BUFFER_CONFIG;
  localparam logic [13:0] ST = `ADCC_IDX_STATUS;
  localparam logic [13:0] RS = `ADCC_IDX_RESULT;
  localparam logic [13:0] CG = `ADCC_IDX_CLOCK_GATES;
  localparam logic [13:0] DR = `ADCC_IDX_DECIM_RESET;
  localparam logic [13:0] SR = `ADCC_IDX_SAMPLE_RATE;

  logic clk_i, reset_n_i, avs_read_i, avs_write_i, avs_waitrequest_o, mod_bit;
  logic [15:0] avs_address_i;
  logic [31:0] avs_writedata_i, avs_readdata_o, rq;
  logic [3:0] avs_byteenable_i, channel_select_o;
  logic sample_clk_o, decim_clk_o, decim_reset_n_o, converter_enable_o;
  int mismatches = 0;
  int checked = 0;
  logic [13:0] di [5] = '{CA, CG, CG, DR, BC};
  logic [7:0] dv [5] = '{8'h00, 8'h04, 8'h08, 8'h00, 8'h30};

  adcc_top #(.MEM_AW(4)) dut (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o), .mod_bit_i(mod_bit),
    .sample_clk_o(sample_clk_o), .decim_clk_o(decim_clk_o), .decim_reset_n_o(decim_reset_n_o),
    .converter_enable_o(converter_enable_o), .channel_select_o(channel_select_o)
  );

  adcc_mod_model partner (
    .clk_i(clk_i), .sample_clk_i(sample_clk_o), .converter_enable_i(converter_enable_o),
    .channel_select_i(channel_select_o), .mod_bit_o(mod_bit)
  );

  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  // ----------------------------------------
  // Bus access and comparison
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Request held until the edge that samples waitrequest low
  task automatic acc(input bit w, input logic [13:0] i, input logic [7:0] d, input logic [3:0] be);
    int n;
    n = 0;
    @(posedge clk_i);
    avs_address_i <= {i, 2'b00};
    avs_read_i <= !w;
    avs_write_i <= w;
    avs_writedata_i <= {24'h0, d};
    avs_byteenable_i <= be;
    do begin
      @(posedge clk_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 100);
    rq = avs_readdata_o;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
    check({31'h0, n < 100}, 32'h1);
  endtask

  task automatic wr(input logic [13:0] i, input logic [7:0] d);
    acc(1'b1, i, d, 4'hF);
    // Registered outputs only settle after the completing edge
    @(negedge clk_i);
  endtask

  task automatic rc(input logic [13:0] i, input logic [7:0] e);
    acc(1'b0, i, 8'h00, 4'hF);
    check(rq, {24'h0, e});
  endtask

  task automatic edges(output int ns, output int nd);
    logic ps, pd;
    ns = 0;
    nd = 0;
    ps = sample_clk_o;
    pd = decim_clk_o;
    repeat (1000) begin
      @(posedge clk_i);
      if (sample_clk_o && !ps) ns++;
      if (decim_clk_o && !pd) nd++;
      ps = sample_clk_o;
      pd = decim_clk_o;
    end
  endtask

  task automatic drain;
    for (int k = 0; k < 20; k++) begin
      acc(1'b0, ST, 8'h00, 4'hF);
      if (rq[6:3] == 4'h0) break;
      acc(1'b0, RS, 8'h00, 4'hF);
      acc(1'b0, RS, 8'h00, 4'hF);
    end
  endtask

  task automatic complete_run;
    if (mismatches == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    int ns, nd, e;
    reset_n_i = 1'b0;
    avs_address_i = 16'h0;
    avs_read_i = 1'b0;
    avs_write_i = 1'b0;
    avs_writedata_i = 32'h0;
    avs_byteenable_i = 4'hF;
    repeat (10) @(posedge clk_i);
    reset_n_i <= 1'b1;
    rc(CA, 8'h00);
    rc(BC, 8'hCC);
    rc(ST, 8'h00);
    rc(RS, 8'h00);
    rc(CG, 8'h00);
    rc(DR, 8'h40);
    rc(SR, 8'h02);
    rc(14'h1000, 8'h00);
    check({31'h0, decim_reset_n_o}, 32'h1);
    for (int c = 0; c < 9; c++) begin
      wr(CA, 8'h80 | 8'(c));
      check({28'h0, channel_select_o}, 32'(c));
      check({31'h0, converter_enable_o}, 32'h1);
    end
    wr(CA, 8'h00);
    check({31'h0, converter_enable_o}, 32'h0);
    wr(DR, 8'h00);
    repeat (50) @(posedge clk_i);
    rc(DR, 8'h00);
    check({31'h0, decim_reset_n_o}, 32'h0);
    wr(DR, 8'h40);
    check({31'h0, decim_reset_n_o}, 32'h1);
    acc(1'b1, SR, 8'h03, 4'hE);
    rc(SR, 8'h02);
    wr(ST, 8'hFF);
    rc(ST, 8'h00);
    // Average edge counts over 20 us, NCO jitter allows one edge
    wr(CG, 8'h0C);
    for (int c = 0; c < 4; c++) begin
      wr(SR, 8'(c));
      repeat (20) @(posedge clk_i);
      edges(ns, nd);
      e = (c == 3) ? 0 : (20 << c);
      check({31'h0, ns >= e - 1 && ns <= e + 1}, 32'h1);
      check({31'h0, nd >= 319 && nd <= 321}, 32'h1);
    end
    wr(SR, 8'h02);
    wr(CG, 8'h00);
    repeat (20) @(posedge clk_i);
    edges(ns, nd);
    check({31'h0, ns == 0 && nd == 0}, 32'h1);
    // FIFO mode, capacity two: midscale kept, later ground discarded
    // First result may hold a stale modulator bit, so it passes unstored
    wr(BC, 8'h06);
    wr(CG, 8'h0C);
    wr(CA, 8'h80);
    repeat (1000) @(posedge clk_i);
    wr(BC, 8'h36);
    repeat (5000) @(posedge clk_i);
    wr(CA, 8'h88);
    repeat (5000) @(posedge clk_i);
    rc(ST, 8'h18);
    repeat (2) begin
      rc(RS, 8'h00);
      rc(RS, 8'h80);
    end
    // History mode: newest ground samples replace midscale
    wr(BC, 8'h34);
    wr(CA, 8'h80);
    repeat (5000) @(posedge clk_i);
    wr(CA, 8'h88);
    repeat (5000) @(posedge clk_i);
    rc(ST, 8'h18);
    repeat (4) rc(RS, 8'h00);
    // Each idle condition stops pushes; restoring resumes them
    wr(CA, 8'h80);
    for (int k = 0; k < 5; k++) begin
      wr(di[k], dv[k]);
      repeat (100) @(posedge clk_i);
      drain();
      repeat (3000) @(posedge clk_i);
      rc(ST, 8'h00);
      wr(CA, 8'h80);
      wr(CG, 8'h0C);
      wr(DR, 8'h40);
      wr(BC, 8'h34);
      repeat (3000) @(posedge clk_i);
      rc(ST, 8'h18);
    end
    // Ratio 256 on a held full-scale input: one saturated result after 3200 cycles
    wr(CA, 8'h87);
    repeat (50) @(posedge clk_i);
    wr(CG, 8'h04);
    drain();
    wr(BC, 8'h3C);
    wr(CG, 8'h0C);
    repeat (3000) @(posedge clk_i);
    rc(ST, 8'h00);
    repeat (400) @(posedge clk_i);
    rc(ST, 8'h10);
    rc(RS, 8'hFF);
    rc(RS, 8'hFF);
    complete_run();
  end

  initial begin
    #1800000;
    mismatches++;
    complete_run();
  end
endmodule // test_adc_digital_control
